// [common/sto_pkg.sv]
package sto_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam logic [8:0] STS1_COLS = 9'h05A;
  localparam logic [8:0] STS3C_COLS = 9'h10E;
  localparam logic [8:0] STS1_TOH = 9'h003;
  localparam logic [8:0] STS3C_TOH = 9'h009;
  localparam logic [8:0] STS1_STUFF_A = 9'h020;
  localparam logic [8:0] STS1_STUFF_B = 9'h03D;
  localparam logic [8:0] STS3C_STUFF_A = 9'h00A;
  localparam logic [8:0] STS3C_STUFF_B = 9'h00B;
  localparam logic [3:0] LAST_ROW = 4'h8;
  localparam logic [1:0] LAST_LANE = 2'h2;

  // ----------------------------------------------------------------
  // overhead rows
  // ----------------------------------------------------------------
  localparam logic [3:0] ROW_FRAMING = 4'h0;
  localparam logic [3:0] ROW_PTR = 4'h3;
  localparam logic [3:0] ROW_B2K = 4'h4;
  localparam logic [3:0] ROW_M = 4'h8;
  localparam logic [3:0] POH_B3 = 4'h1;
  localparam logic [3:0] POH_C2 = 4'h2;
  localparam logic [3:0] POH_G1 = 4'h3;
  localparam logic [3:0] POH_H4 = 4'h5;

  // ----------------------------------------------------------------
  // fixed byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_A1 = 8'hF6;
  localparam logic [7:0] BYTE_A2 = 8'h28;
  localparam logic [7:0] BYTE_J0 = 8'h01;
  localparam logic [7:0] BYTE_Z0_2 = 8'h02;
  localparam logic [7:0] BYTE_Z0_3 = 8'h03;
  localparam logic [7:0] BYTE_H1_FIRST = 8'h62;
  localparam logic [7:0] BYTE_H1_CONC = 8'h93;
  localparam logic [7:0] BYTE_H2_FIRST = 8'h0A;
  localparam logic [7:0] BYTE_H2_CONC = 8'hFF;
  localparam logic [7:0] BYTE_K2_RDI = 8'h06;
  localparam logic [7:0] BYTE_C2_ATM = 8'h13;
  localparam logic [7:0] BYTE_FILL = 8'h00;

  // ----------------------------------------------------------------
  // cells and error counts
  // ----------------------------------------------------------------
  localparam logic [5:0] CELL_LEN = 6'h35;
  localparam logic [5:0] CELL_LAST = 6'h34;
  localparam logic [5:0] CELL_HDR4 = 6'h03;
  localparam logic [5:0] CELL_HCS = 6'h04;
  localparam logic [7:0] IDLE_HDR4 = 8'h01;
  localparam logic [7:0] IDLE_HCS = 8'h52;
  localparam logic [7:0] IDLE_PAYLOAD = 8'h6A;
  localparam logic [7:0] PFEBE_MAX = 8'h08;
  localparam logic [7:0] PFEBE_FORCED = 8'h01;
  localparam logic [7:0] COUNT_SAT = 8'hFF;

  typedef enum logic [1:0] {
    SLOT_TOH = 2'b00,
    SLOT_POH = 2'b01,
    SLOT_STUFF = 2'b10,
    SLOT_PAY = 2'b11
  } sto_slot_e;

endpackage

// [common/sto_stream_if.sv]
interface sto_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// [hw/sto_buf2.sv]
// two-entry buffer; in_ready is registered and drops when both are full
module sto_buf2 (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  sto_stream_if.src out
);

  logic [7:0] head_q, head_d, tail_q, tail_d;
  logic [1:0] cnt_q, cnt_d;
  logic in_ready_q, in_ready_d;
  logic push, pop;

  assign in_ready = in_ready_q;
  assign out.valid = (cnt_q != 2'h0);
  assign out.data = head_q;

  always_comb begin
    push = in_valid && in_ready_q;
    pop = out.valid && out.ready;
    cnt_d = 2'((cnt_q + {1'b0, push}) - {1'b0, pop});
    head_d = pop ? tail_q : head_q;
    tail_d = tail_q;
    if (push) begin
      if ((cnt_q - {1'b0, pop}) == 2'h0) begin
        head_d = in_data;
      end else begin
        tail_d = in_data;
      end
    end
    in_ready_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      head_q <= 8'h00;
      tail_q <= 8'h00;
      cnt_q <= 2'h0;
      in_ready_q <= 1'b1;
    end else if (ce) begin
      head_q <= head_d;
      tail_q <= tail_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
    end
  end

endmodule

// [hw/sto_tx_overhead.sv]
module sto_tx_overhead (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sts3c_mode,
  input wire logic line_rdi_en,
  input wire logic b2_corrupt,
  input wire logic b3_corrupt,
  input wire logic path_febe_force,
  input wire logic line_bip_err,
  input wire logic path_bip_err,
  input wire logic cell_avail,
  input wire logic [7:0] cell_data,
  input wire logic cell_valid,
  output logic cell_ready,
  output logic [7:0] tx_data,
  output logic tx_frame_start
);

  sto_stream_if cell_if ();

  sto_buf2 u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .in_data(cell_data),
    .in_valid(cell_valid),
    .in_ready(cell_ready),
    .out(cell_if.src)
  );

  // ----------------------------------------------------------------
  // time slot counter
  // ----------------------------------------------------------------
  logic mode_q, mode_d;
  logic [3:0] row_q, row_d;
  logic [8:0] col_q, col_d;
  logic [1:0] lane_q, lane_d;
  logic [8:0] row_len, toh_cols;
  logic col_last, frame_end;
  logic [1:0] grp, idx;
  sto_pkg::sto_slot_e slot;

  always_comb begin
    row_len = mode_q ? sto_pkg::STS3C_COLS : sto_pkg::STS1_COLS;
    toh_cols = mode_q ? sto_pkg::STS3C_TOH : sto_pkg::STS1_TOH;
    col_last = (col_q == 9'(row_len - 9'h001));
    frame_end = col_last && (row_q == sto_pkg::LAST_ROW);
    idx = mode_q ? lane_q : 2'h0;
    if (!mode_q) begin
      grp = col_q[1:0];
    end else if (col_q < 9'h003) begin
      grp = 2'h0;
    end else if (col_q < 9'h006) begin
      grp = 2'h1;
    end else begin
      grp = 2'h2;
    end
    // pointer fixed at offset 522: payload aligned to the frame rows
    if (col_q < toh_cols) begin
      slot = sto_pkg::SLOT_TOH;
    end else if (col_q == toh_cols) begin
      slot = sto_pkg::SLOT_POH;
    end else if (mode_q ? (col_q == sto_pkg::STS3C_STUFF_A ||
                           col_q == sto_pkg::STS3C_STUFF_B)
                        : (col_q == sto_pkg::STS1_STUFF_A ||
                           col_q == sto_pkg::STS1_STUFF_B)) begin
      slot = sto_pkg::SLOT_STUFF;
    end else begin
      slot = sto_pkg::SLOT_PAY;
    end
    col_d = col_last ? 9'h000 : 9'(col_q + 9'h001);
    row_d = row_q;
    if (col_last) begin
      row_d = frame_end ? 4'h0 : 4'(row_q + 4'h1);
    end
    if (col_last || !mode_q || lane_q == sto_pkg::LAST_LANE) begin
      lane_d = 2'h0;
    end else begin
      lane_d = 2'(lane_q + 2'h1);
    end
    // mode changes only on a frame boundary
    mode_d = frame_end ? sts3c_mode : mode_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= 1'b0;
      row_q <= 4'h0;
      col_q <= 9'h000;
      lane_q <= 2'h0;
    end else if (ce) begin
      mode_q <= mode_d;
      row_q <= row_d;
      col_q <= col_d;
      lane_q <= lane_d;
    end
  end

  // ----------------------------------------------------------------
  // cell source and idle cells
  // ----------------------------------------------------------------
  logic [5:0] cell_pos_q, cell_pos_d;
  logic idle_q, idle_d, idle_now, pay_slot;
  logic [7:0] cell_byte, h4_byte;

  assign cell_if.ready = ce && pay_slot && !idle_now;

  always_comb begin
    pay_slot = (slot == sto_pkg::SLOT_PAY);
    idle_now = idle_q;
    if (cell_pos_q == 6'h00) begin
      idle_now = !(cell_avail && cell_if.valid);
    end
    if (!idle_now) begin
      cell_byte = cell_if.valid ? cell_if.data : sto_pkg::BYTE_FILL;
    end else if (cell_pos_q < sto_pkg::CELL_HDR4) begin
      cell_byte = sto_pkg::BYTE_FILL;
    end else if (cell_pos_q == sto_pkg::CELL_HDR4) begin
      cell_byte = sto_pkg::IDLE_HDR4;
    end else if (cell_pos_q == sto_pkg::CELL_HCS) begin
      cell_byte = sto_pkg::IDLE_HCS;
    end else begin
      cell_byte = sto_pkg::IDLE_PAYLOAD;
    end
    cell_pos_d = cell_pos_q;
    idle_d = idle_q;
    if (pay_slot) begin
      cell_pos_d = (cell_pos_q == sto_pkg::CELL_LAST) ? 6'h00
                                                      : 6'(cell_pos_q + 6'h01);
      idle_d = idle_now;
    end
    h4_byte = 8'h00;
    if (cell_pos_q != 6'h00) begin
      h4_byte = {2'b00, 6'(sto_pkg::CELL_LEN - cell_pos_q)};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cell_pos_q <= 6'h00;
      idle_q <= 1'b1;
    end else if (ce) begin
      cell_pos_q <= cell_pos_d;
      idle_q <= idle_d;
    end
  end

  // ----------------------------------------------------------------
  // far-end error accumulators
  // ----------------------------------------------------------------
  logic [7:0] lfebe_q, lfebe_d, pfebe_q, pfebe_d, pfebe_sent, pfebe_base;
  logic m_slot, g1_slot;

  always_comb begin
    m_slot = (slot == sto_pkg::SLOT_TOH) && (row_q == sto_pkg::ROW_M) &&
             (grp == 2'h1) && (idx == (mode_q ? 2'h2 : 2'h0));
    g1_slot = (slot == sto_pkg::SLOT_POH) && (row_q == sto_pkg::POH_G1);
    // an error in the send cycle starts the next count
    if (m_slot) begin
      lfebe_d = {7'h00, line_bip_err};
    end else if (line_bip_err && lfebe_q != sto_pkg::COUNT_SAT) begin
      lfebe_d = 8'(lfebe_q + 8'h01);
    end else begin
      lfebe_d = lfebe_q;
    end
    if (path_febe_force) begin
      pfebe_sent = sto_pkg::PFEBE_FORCED;
    end else if (pfebe_q > sto_pkg::PFEBE_MAX) begin
      pfebe_sent = sto_pkg::PFEBE_MAX;
    end else begin
      pfebe_sent = pfebe_q;
    end
    pfebe_base = pfebe_q;
    if (g1_slot && !path_febe_force) begin
      pfebe_base = 8'(pfebe_q - pfebe_sent);
    end
    pfebe_d = pfebe_base;
    if (path_bip_err && pfebe_base != sto_pkg::COUNT_SAT) begin
      pfebe_d = 8'(pfebe_base + 8'h01);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfebe_q <= 8'h00;
      pfebe_q <= 8'h00;
    end else if (ce) begin
      lfebe_q <= lfebe_d;
      pfebe_q <= pfebe_d;
    end
  end

  // ----------------------------------------------------------------
  // parity accumulation
  // ----------------------------------------------------------------
  logic [2:0][7:0] b2_acc_q, b2_acc_d, b2_val_q, b2_val_d;
  logic [7:0] b3_acc_q, b3_acc_d, b3_val_q, b3_val_d;
  logic [7:0] out_d;
  logic line_cov;

  assign line_cov = (row_q >= sto_pkg::ROW_PTR) || (col_q >= toh_cols);

  for (genvar i = 0; i < 3; i++) begin : g_lane
    logic [7:0] term;
    assign term = (line_cov && idx == 2'(i)) ? out_d : 8'h00;
    assign b2_acc_d[i] = frame_end ? 8'h00 : (b2_acc_q[i] ^ term);
    assign b2_val_d[i] = frame_end ? (b2_acc_q[i] ^ term) : b2_val_q[i];
  end

  always_comb begin
    b3_acc_d = b3_acc_q;
    b3_val_d = b3_val_q;
    if (col_q >= toh_cols) begin
      b3_acc_d = b3_acc_q ^ out_d;
    end
    if (frame_end) begin
      b3_val_d = b3_acc_d;
      b3_acc_d = 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b2_acc_q <= '0;
      b2_val_q <= '0;
      b3_acc_q <= 8'h00;
      b3_val_q <= 8'h00;
    end else if (ce) begin
      b2_acc_q <= b2_acc_d;
      b2_val_q <= b2_val_d;
      b3_acc_q <= b3_acc_d;
      b3_val_q <= b3_val_d;
    end
  end

  // ----------------------------------------------------------------
  // stream multiplexer
  // ----------------------------------------------------------------
  logic [7:0] toh_byte, poh_byte;
  logic start_d;

  always_comb begin
    toh_byte = sto_pkg::BYTE_FILL;
    case (row_q)
      sto_pkg::ROW_FRAMING: begin
        if (grp == 2'h0) begin
          toh_byte = sto_pkg::BYTE_A1;
        end else if (grp == 2'h1) begin
          toh_byte = sto_pkg::BYTE_A2;
        end else if (idx == 2'h0) begin
          toh_byte = sto_pkg::BYTE_J0;
        end else begin
          toh_byte = (idx == 2'h1) ? sto_pkg::BYTE_Z0_2 : sto_pkg::BYTE_Z0_3;
        end
      end
      sto_pkg::ROW_PTR: begin
        if (grp == 2'h0) begin
          toh_byte = (idx == 2'h0) ? sto_pkg::BYTE_H1_FIRST
                                   : sto_pkg::BYTE_H1_CONC;
        end else if (grp == 2'h1) begin
          toh_byte = (idx == 2'h0) ? sto_pkg::BYTE_H2_FIRST
                                   : sto_pkg::BYTE_H2_CONC;
        end
      end
      sto_pkg::ROW_B2K: begin
        if (grp == 2'h0) begin
          toh_byte = b2_val_q[idx] ^ {8{b2_corrupt}};
        end else if (grp == 2'h2 && idx == 2'h0 && line_rdi_en) begin
          toh_byte = sto_pkg::BYTE_K2_RDI;
        end
      end
      sto_pkg::ROW_M: begin
        if (m_slot) begin
          toh_byte = lfebe_q;
        end
      end
      default: toh_byte = sto_pkg::BYTE_FILL;
    endcase
    case (row_q)
      sto_pkg::POH_B3: poh_byte = b3_val_q ^ {8{b3_corrupt}};
      sto_pkg::POH_C2: poh_byte = sto_pkg::BYTE_C2_ATM;
      sto_pkg::POH_G1: poh_byte = {pfebe_sent[3:0], 4'h0};
      sto_pkg::POH_H4: poh_byte = h4_byte;
      default: poh_byte = sto_pkg::BYTE_FILL;
    endcase
    case (slot)
      sto_pkg::SLOT_TOH: out_d = toh_byte;
      sto_pkg::SLOT_POH: out_d = poh_byte;
      sto_pkg::SLOT_STUFF: out_d = sto_pkg::BYTE_FILL;
      sto_pkg::SLOT_PAY: out_d = cell_byte;
      default: out_d = sto_pkg::BYTE_FILL;
    endcase
    start_d = (row_q == 4'h0) && (col_q == 9'h000);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data <= 8'h00;
      tx_frame_start <= 1'b0;
    end else if (ce) begin
      tx_data <= out_d;
      tx_frame_start <= start_d;
    end
  end

endmodule

// [testbench/sto_tx_overhead_monitor.sv]
// ----------------------------------------------------------------
// port checker for the overhead generator
// ----------------------------------------------------------------
module sto_tx_overhead_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sts3c_mode,
  input wire logic line_rdi_en,
  input wire logic b2_corrupt,
  input wire logic b3_corrupt,
  input wire logic path_febe_force,
  input wire logic line_bip_err,
  input wire logic path_bip_err,
  input wire logic cell_avail,
  input wire logic [7:0] cell_data,
  input wire logic cell_valid,
  input wire logic cell_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_frame_start
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q;
  int pos;
  logic s3_q;
  logic seen_q;
  // byte position inside the frame on the line
  assign pos = tx_frame_start ? 0 : cnt_q;
  always_ff @(posedge sys_clk) begin
    if (ce && rst) begin
      cnt_q <= 0;
      seen_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= pos + 1;
      seen_q <= seen_q | tx_frame_start;
      s3_q <= (pos == 1) ? (tx_data == 8'hF6) : s3_q;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || !ce);
  AST_RST_OUT: assert property (disable iff (1'b0) rst && ce |=>
    !tx_frame_start && cell_ready && tx_data == 8'h00)
    else $error("outputs not at reset values");
  AST_REL_A1: assert property (disable iff (!ce) rst ##1 !rst |=>
    tx_frame_start && tx_data == 8'hF6)
    else $error("first byte after reset is not a frame start");
  AST_FRAME_LEN: assert property (tx_frame_start && seen_q |->
    cnt_q == 810 || cnt_q == 2430)
    else $error("frame length wrong");
  AST_ROW0: assert property (tx_frame_start |-> tx_data == 8'hF6
    ##1 ((tx_data == 8'h28 ##1 tx_data == 8'h01) or
    (tx_data == 8'hF6 [*2] ##1 tx_data == 8'h28 [*3] ##1
    tx_data == 8'h01 ##1 tx_data == 8'h02 ##1 tx_data == 8'h03)))
    else $error("framing row wrong");
  AST_PTR3: assert property (s3_q && pos == 810 |->
    tx_data == 8'h62 ##1 tx_data == 8'h93 [*2] ##1 tx_data == 8'h0A ##1
    tx_data == 8'hFF [*2] ##1 tx_data == 8'h00 [*3])
    else $error("concatenated pointer row wrong");
  AST_PTR1: assert property (!s3_q && seen_q && pos == 270 |->
    tx_data == 8'h62 ##1 tx_data == 8'h0A ##1 tx_data == 8'h00)
    else $error("single pointer row wrong");
  AST_K2: assert property (seen_q && $stable(line_rdi_en) &&
    pos == (s3_q ? 1086 : 362) |-> tx_data == (line_rdi_en ? 8'h06 : 8'h00))
    else $error("remote defect byte wrong");
  AST_G1: assert property (seen_q && pos == (s3_q ? 819 : 273) |->
    tx_data[3:0] == 4'h0 && tx_data[7:4] <= 4'h8)
    else $error("path status byte out of range");
  AST_READY_FALL: assert property ($fell(cell_ready) |->
    $past(cell_valid) || $past(cell_valid, 2))
    else $error("buffer full without a word taken");
  cover property (tx_frame_start && s3_q);
  cover property ($fell(cell_ready));
  cover property (pos == 819 && tx_data[7:4] == 4'h8);
endmodule

bind sto_tx_overhead sto_tx_overhead_monitor i_mon (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .sts3c_mode(sts3c_mode),
  .line_rdi_en(line_rdi_en), .b2_corrupt(b2_corrupt),
  .b3_corrupt(b3_corrupt), .path_febe_force(path_febe_force),
  .line_bip_err(line_bip_err), .path_bip_err(path_bip_err),
  .cell_avail(cell_avail), .cell_data(cell_data), .cell_valid(cell_valid),
  .cell_ready(cell_ready), .tx_data(tx_data),
  .tx_frame_start(tx_frame_start));

// [testbench/sto_line_rx_model.sv]
// ----------------------------------------------------------------
// line side: takes one byte per enabled cycle, stores the frame
// ----------------------------------------------------------------
module sto_line_rx_model (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic [7:0] tx_data,
  input wire logic tx_frame_start,
  output int pos,
  output logic [7:0] frm [2430]
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge sys_clk) begin
    if (ce) begin
      pos <= tx_frame_start ? 0 : pos + 1;
      frm[tx_frame_start ? 0 : (pos + 1) % 2430] <= tx_data;
    end
  end
endmodule

// [testbench/sto_tx_overhead_tb.sv]
module sto_tx_overhead_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic sts3c_mode = 1'b0;
  logic line_rdi_en = 1'b0;
  logic b2_corrupt = 1'b0;
  logic b3_corrupt = 1'b0;
  logic path_febe_force = 1'b0;
  logic line_bip_err = 1'b0;
  logic path_bip_err = 1'b0;
  logic cell_avail = 1'b0;
  logic [7:0] cell_data = 8'h00;
  logic cell_valid = 1'b0;
  logic cell_ready;
  logic [7:0] tx_data;
  logic tx_frame_start;
  logic [7:0] frm [2430];
  int pos;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_c3 = 0;
  int cols = 90;
  int toh = 3;

  always #20 sys_clk = ~sys_clk;

  sto_tx_overhead i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .sts3c_mode(sts3c_mode), .line_rdi_en(line_rdi_en),
    .b2_corrupt(b2_corrupt), .b3_corrupt(b3_corrupt),
    .path_febe_force(path_febe_force), .line_bip_err(line_bip_err),
    .path_bip_err(path_bip_err), .cell_avail(cell_avail),
    .cell_data(cell_data), .cell_valid(cell_valid),
    .cell_ready(cell_ready), .tx_data(tx_data),
    .tx_frame_start(tx_frame_start));
  sto_line_rx_model i_rx (.sys_clk(sys_clk), .ce(ce), .tx_data(tx_data),
    .tx_frame_start(tx_frame_start), .pos(pos), .frm(frm));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!tx_frame_start && tx_data == 8'hC3 && (pos + 1) % cols > toh)
      n_c3 <= n_c3 + 1;
    if (cyc == 90000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_pos(input int p);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (pos != p && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (pos != p) begin
      n_mismatch++;
      $display("[ERR] position expected %0d seen %0d", p, pos);
    end
  endtask

  task automatic pulse(input int n, input bit path);
    for (int i = 0; i < n; i++) begin
      if (path) path_bip_err <= 1'b1;
      else line_bip_err <= 1'b1;
      @(posedge sys_clk);
    end
    path_bip_err <= 1'b0;
    line_bip_err <= 1'b0;
  endtask

  function automatic logic [7:0] bip(input int lane, input bit line);
    logic [7:0] p;
    int c;
    p = 8'h00;
    for (int i = 0; i < 9 * cols; i++) begin
      c = i % cols;
      if (line && (i >= 3 * cols || c >= toh) && c % (toh / 3) == lane)
        p = p ^ frm[i];
      if (!line && c >= toh)
        p = p ^ frm[i];
    end
    return p;
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_toh(input bit s3);
    logic [7:0] ra [9] = '{8'hF6, 8'hF6, 8'hF6, 8'h28, 8'h28, 8'h28,
                           8'h01, 8'h02, 8'h03};
    logic [7:0] rp [9] = '{8'h62, 8'h93, 8'h93, 8'h0A, 8'hFF, 8'hFF,
                           8'h00, 8'h00, 8'h00};
    logic [7:0] e;
    int j;
    sts3c_mode <= s3;
    wait_pos(0);
    wait_pos(0);
    cols = s3 ? 270 : 90;
    toh = s3 ? 9 : 3;
    for (int r = 0; r < 9; r++)
      for (int c = 0; c < toh; c++) begin
        j = s3 ? c : 3 * c;
        e = r == 0 ? ra[j] : (r == 3 ? rp[j] : 8'h00);
        if (r != 4 || c >= toh / 3)
          chk("toh", e, frm[r * cols + c]);
      end
    chk("j1", 8'h00, frm[toh]);
    chk("c2", 8'h13, frm[2 * cols + toh]);
    chk("g1", 8'h00, frm[3 * cols + toh]);
    chk("stuff", 8'h00, frm[s3 ? 10 : 32]);
    $display("test toh done");
  endtask

  task automatic t_par();
    logic [7:0] e [4];
    for (int k = 0; k < 2; k++) begin
      b2_corrupt <= k[0];
      b3_corrupt <= k[0];
      wait_pos(0);
      for (int l = 0; l < 3; l++) e[l] = bip(l, 1'b1);
      e[3] = bip(0, 1'b0);
      wait_pos(5 * cols);
      for (int l = 0; l < 3; l++)
        chk("b2", e[l] ^ {8{k[0]}}, frm[4 * cols + l]);
      chk("b3", e[3] ^ {8{k[0]}}, frm[cols + toh]);
    end
    b2_corrupt <= 1'b0;
    b3_corrupt <= 1'b0;
    $display("test parity done");
  endtask

  task automatic t_rdi();
    line_rdi_en <= 1'b1;
    wait_pos(0);
    wait_pos(5 * cols);
    chk("k2", 8'h06, frm[4 * cols + 6]);
    line_rdi_en <= 1'b0;
    $display("test rdi done");
  endtask

  task automatic t_lfebe();
    int n [2] = '{5, 300};
    for (int k = 0; k < 2; k++) begin
      wait_pos(0);
      pulse(n[k], 1'b0);
      wait_pos(8 * cols + 5);
      chk("m1", n[k] > 255 ? 8'hFF : 8'(n[k]),
          frm[8 * cols + 5]);
    end
    $display("test line febe done");
  endtask

  task automatic t_pfebe();
    logic [7:0] e [4] = '{8'h80, 8'h30, 8'h10, 8'h30};
    for (int f = 0; f < 4; f++) begin
      wait_pos(0);
      path_febe_force <= (f == 2);
      if (f == 0 || f == 2) pulse(f == 0 ? 11 : 3, 1'b1);
      wait_pos(3 * cols + toh);
      chk("g1", e[f], frm[3 * cols + toh]);
    end
    path_febe_force <= 1'b0;
    $display("test path febe done");
  endtask

  task automatic t_cells();
    bit full;
    bit idle;
    int base;
    int at;
    int left;
    int cc;
    full = 1'b0;
    idle = 1'b0;
    wait_pos(0);
    for (int i = 0; i < 9 * cols - 2; i++)
      if (frm[i] == 8'h01 && frm[i + 1] == 8'h52 && frm[i + 2] == 8'h6A)
        idle = 1'b1;
    chk("idle", 8'h01, {7'h00, idle});
    // walk the payload from H4 to the fourth byte of the next cell
    at = 5 * cols + toh;
    left = int'(frm[at]) + 4;
    while (left > 0 && at < 9 * cols - 1) begin
      at++;
      cc = at % cols;
      if (cc > toh && cc != (toh == 9 ? 10 : 32) &&
          cc != (toh == 9 ? 11 : 61))
        left--;
    end
    chk("h4", 8'h01, frm[at]);
    base = n_c3;
    cell_avail <= 1'b1;
    for (int i = 0; i < 53; i++) begin
      cell_valid <= 1'b1;
      cell_data <= i < 5 ? 8'(8'h11 * (i + 1)) : 8'hC3;
      @(posedge sys_clk);
      while (!cell_ready) begin
        full = 1'b1;
        @(posedge sys_clk);
      end
    end
    cell_valid <= 1'b0;
    cell_avail <= 1'b0;
    wait_pos(0);
    wait_pos(0);
    chk("full", 8'h01, {7'h00, full});
    chk("cell", 8'h30, 8'(n_c3 - base));
    $display("test cells done");
  endtask

  task automatic t_ce();
    wait_pos(0);
    ce <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("ce hold", 8'hF6, tx_data);
    ce <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("ce resume", 8'h28, tx_data);
    $display("test clock enable done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_toh(1'b0);
    t_toh(1'b1);
    t_ce();
    t_par();
    t_rdi();
    t_lfebe();
    t_pfebe();
    t_cells();
    results();
  end
endmodule
